/* File: design/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

	// Register byte offsets on the AXI4-Lite port.
	localparam logic [7:0] prio_ctrl_offset    = 8'h00;
	localparam logic [7:0] hw_trig_offset      = 8'h04;
	localparam logic [7:0] mon0_cfg_offset     = 8'h08;
	localparam logic [7:0] mon0_compare_offset = 8'h0c;
	localparam logic [7:0] norm_ctrl_offset    = 8'h10;
	localparam logic [7:0] irq_status_offset   = 8'h14;
	localparam logic [7:0] irq_mask_offset     = 8'h18;

	// Priority control fields.
	localparam int prio_done_pos  = 7;
	localparam int prio_busy_pos  = 6;
	localparam int prio_start_pos = 5;
	localparam int prio_chan_lsb  = 0;

	// Trigger and soft reset fields.
	localparam int prio_src_pos   = 7;
	localparam int prio_hwen_pos  = 6;
	localparam int norm_src_pos   = 5;
	localparam int norm_hwen_pos  = 4;

	// Monitor configuration fields.
	localparam int mon0_dir_pos   = 5;
	localparam int mon0_sel_lsb   = 1;
	localparam int mon0_en_pos    = 0;

	// Normal control fields (block-local).
	localparam int norm_start_pos = 0;
	localparam int norm_busy_pos  = 1;

	// Interrupt status bits.
	localparam int irq_prio_done_pos = 0;
	localparam int irq_norm_done_pos = 1;
	localparam int irq_mon0_pos      = 2;

	localparam logic [1:0] soft_reset_arm  = 2'h2;
	localparam logic [1:0] soft_reset_fire = 2'h1;
	localparam logic [3:0] prio_chan_min   = 4'h4;
	localparam logic [3:0] prio_chan_max   = 4'hb;

	localparam logic [7:0] prio_ctrl_reset  = 8'h00;
	localparam logic [7:0] hw_trig_reset    = 8'h00;
	localparam logic [7:0] mon0_cfg_reset   = 8'h00;
	localparam logic [9:0] mon0_cmp_reset   = 10'h000;
	localparam logic [2:0] irq_mask_reset   = 3'h0;

	// Default conversion time in clocks.
	localparam int conv_cycles_default = 20;

	typedef enum logic [1:0] {
		conv_idle = 2'b00,
		conv_norm = 2'b01,
		conv_prio = 2'b11
	} conv_state_type;

endpackage

/* File: design/adc_priority_trigger_monitor_ctrl.sv */
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - Completion flag bit 7 is 0 before or during priority conversion, 1 after completion.
// - Reading the priority control register clears the completion flag.
// - Busy flag bit 6 is 1 while a priority conversion runs.
// - Writing 1 to start bit 5 launches a priority conversion; reads as 0.
// - Channel codes 0100 to 1011 select inputs 4 to 11; others prohibited.
// - Priority source bit 7: 0 external trigger, 1 timer five compare 0.
// - Priority hardware enable bit 6 gates hardware priority starts.
// - Normal source bit 5: 0 external trigger, 1 timer six compare 0.
// - Normal hardware enable bit 4 gates hardware normal starts.
// - External trigger used for priority is not accepted for normal starts.
// - Writing 10 then 01 to bits 1-0 performs a software reset.
// - Software reset restores all registers except the conversion clock setting.
// - Monitor direction 0 interrupts on result below compare, 1 on above.
// - Monitor target 0000-0111 picks normal results 0-7; 1xxx picks priority result.
// - Monitor enable bit 0 switches the comparison off or on.
module adc_priority_trigger_monitor_ctrl #(
	parameter int conv_cycles = adc_ctrl_pkg::conv_cycles_default
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic         ext_trigger,
	input  wire logic         timer5_compare0,
	input  wire logic         timer6_compare0,
	input  wire logic [9:0]   conv_result,
	input  wire logic [79:0]  normal_results,
	input  wire logic [9:0]   prio_result_register,
	output logic              conv_start,
	output logic [3:0]        conv_channel,
	output logic              conv_is_prio,
	output logic              soft_reset_pulse,
	output logic              irq
);

	logic [3:0]  prio_chan_reg;
	logic        prio_done_reg;
	logic [7:4]  hw_trig_reg;
	logic [5:0]  mon0_cfg_reg;
	logic [9:0]  mon0_cmp_reg;
	logic [3:0]  norm_chan_reg;
	logic [2:0]  irq_status_reg;
	logic [2:0]  irq_mask_reg;
	logic        soft_arm_reg;
	logic        prio_pend_reg;
	logic        norm_pend_reg;
	logic        norm_resume_reg;
	logic [15:0] conv_cnt_reg;
	adc_ctrl_pkg::conv_state_type state_reg;
	adc_ctrl_pkg::conv_state_type state_next;

	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;

	// Write channel: address and data are caught independently, then applied together.
	wire aw_take   = s_axi_awvalid && s_axi_awready;
	wire w_take    = s_axi_wvalid && s_axi_wready;
	wire wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
	wire [7:0] wa  = aw_addr_reg;
	wire [7:0] wd  = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
	wire wr_low    = wr_fire && w_strb_reg[0];
	wire wr_hi     = wr_fire && w_strb_reg[1];
	wire wr_prio   = wr_low && (wa == adc_ctrl_pkg::prio_ctrl_offset);
	wire wr_trig   = wr_low && (wa == adc_ctrl_pkg::hw_trig_offset);
	wire wr_mon    = wr_low && (wa == adc_ctrl_pkg::mon0_cfg_offset);
	wire wr_cmp    = wr_fire && (wa == adc_ctrl_pkg::mon0_compare_offset);
	wire wr_norm   = wr_low && (wa == adc_ctrl_pkg::norm_ctrl_offset);
	wire wr_stat   = wr_low && (wa == adc_ctrl_pkg::irq_status_offset);
	wire wr_mask   = wr_low && (wa == adc_ctrl_pkg::irq_mask_offset);
	wire wr_known  = (wa <= adc_ctrl_pkg::irq_mask_offset) && (wa[1:0] == 2'h0);

	// Two-step reset: arm on 10, fire on a following 01.
	wire soft_fire = wr_trig && soft_arm_reg &&
		(wd[1:0] == adc_ctrl_pkg::soft_reset_fire);

	// Read decode.
	wire rd_take   = s_axi_arvalid && s_axi_arready;
	wire [7:0] ra  = s_axi_araddr;
	wire rd_prio   = rd_take && (ra == adc_ctrl_pkg::prio_ctrl_offset);
	wire rd_known  = (ra <= adc_ctrl_pkg::irq_mask_offset) && (ra[1:0] == 2'h0);
	wire prio_busy = (state_reg == adc_ctrl_pkg::conv_prio);
	wire norm_busy = (state_reg == adc_ctrl_pkg::conv_norm) || norm_resume_reg;
	wire [7:0] prio_view = {prio_done_reg, prio_busy, 1'b0, 1'b0, prio_chan_reg};
	wire [31:0] prio_word = {24'h000000, prio_view};
	wire [31:0] trig_word = {24'h000000, hw_trig_reg, 4'h0};
	wire [31:0] mon_word  = {26'h0000000, mon0_cfg_reg};
	wire [31:0] cmp_word  = {22'h000000, mon0_cmp_reg};
	wire [31:0] norm_word = {24'h000000, norm_chan_reg, 2'h0, norm_busy, 1'b0};
	wire [31:0] stat_word = {29'h00000000, irq_status_reg};
	wire [31:0] mask_word = {29'h00000000, irq_mask_reg};
	wire [31:0] rd_word =
		(ra == adc_ctrl_pkg::prio_ctrl_offset)    ? prio_word :
		(ra == adc_ctrl_pkg::hw_trig_offset)      ? trig_word :
		(ra == adc_ctrl_pkg::mon0_cfg_offset)     ? mon_word :
		(ra == adc_ctrl_pkg::mon0_compare_offset) ? cmp_word :
		(ra == adc_ctrl_pkg::norm_ctrl_offset)    ? norm_word :
		(ra == adc_ctrl_pkg::irq_status_offset)   ? stat_word :
		(ra == adc_ctrl_pkg::irq_mask_offset)     ? mask_word :
		32'h00000000;

	// Prohibited channel codes are dropped, keeping the channel already held (priority resets to 0000).
	function automatic logic chan_legal(input logic [3:0] code);
		chan_legal = (code >= adc_ctrl_pkg::prio_chan_min) &&
			(code <= adc_ctrl_pkg::prio_chan_max);
	endfunction

	// Hardware triggers; the external trigger belongs to the priority path when it owns it.
	wire ext_owned_prio = hw_trig_reg[adc_ctrl_pkg::prio_hwen_pos] &&
		!hw_trig_reg[adc_ctrl_pkg::prio_src_pos];
	wire prio_hw_evt = hw_trig_reg[adc_ctrl_pkg::prio_hwen_pos] &&
		(hw_trig_reg[adc_ctrl_pkg::prio_src_pos] ? timer5_compare0 : ext_trigger);
	wire norm_hw_evt = hw_trig_reg[adc_ctrl_pkg::norm_hwen_pos] &&
		(hw_trig_reg[adc_ctrl_pkg::norm_src_pos] ? timer6_compare0 :
		(ext_trigger && !ext_owned_prio));
	wire prio_sw_evt = wr_prio && wd[adc_ctrl_pkg::prio_start_pos];
	wire norm_sw_evt = wr_norm && wd[adc_ctrl_pkg::norm_start_pos];

	// A channel written together with its start bit is the one that gets converted.
	wire prio_chan_ok = wr_prio && chan_legal(wd[3:0]);
	wire norm_chan_ok = wr_norm && chan_legal(wd[7:4]);
	wire [3:0] prio_chan_eff = prio_chan_ok ? wd[3:0] : prio_chan_reg;
	wire [3:0] norm_chan_eff = norm_chan_ok ? wd[7:4] : norm_chan_reg;
	wire prio_req = prio_sw_evt || prio_hw_evt || prio_pend_reg;
	wire norm_req = norm_sw_evt || norm_hw_evt || norm_pend_reg;

	// Conversion sequencer; priority wins every arbitration.
	wire conv_last = (conv_cnt_reg == 16'(conv_cycles - 1));
	wire conv_end  = (state_reg != adc_ctrl_pkg::conv_idle) && conv_last;
	wire prio_end  = conv_end && prio_busy;
	wire norm_end  = conv_end && (state_reg == adc_ctrl_pkg::conv_norm);
	wire preempt   = (state_reg == adc_ctrl_pkg::conv_norm) && prio_req;
	wire go_prio   = prio_req && (state_reg == adc_ctrl_pkg::conv_idle || preempt ||
		conv_end);
	wire go_norm   = !go_prio && (norm_req || norm_resume_reg) &&
		(state_reg == adc_ctrl_pkg::conv_idle || conv_end);

	always_comb begin
		state_next = state_reg;
		if (go_prio) begin
			state_next = adc_ctrl_pkg::conv_prio;
		end else if (go_norm) begin
			state_next = adc_ctrl_pkg::conv_norm;
		end else if (conv_end) begin
			state_next = adc_ctrl_pkg::conv_idle;
		end
	end

	// Monitor 0 compares the chosen result at every normal or priority completion.
	function automatic logic [9:0] pick_result(input logic [3:0] sel, input logic [79:0] n,
		input logic [9:0] p);
		if (sel[3]) begin
			pick_result = p;
		end else begin
			pick_result = n[sel[2:0]*10 +: 10];
		end
	endfunction

	wire [9:0] mon_value = pick_result(mon0_cfg_reg[4:1], normal_results,
		prio_result_register);
	wire mon_hit = mon0_cfg_reg[adc_ctrl_pkg::mon0_dir_pos] ? (mon_value > mon0_cmp_reg) :
		(mon_value < mon0_cmp_reg);
	wire mon_evt = conv_end && mon0_cfg_reg[adc_ctrl_pkg::mon0_en_pos] && mon_hit;
	wire [2:0] irq_set = {mon_evt, norm_end, prio_end};
	wire [2:0] irq_clr = wr_stat ? wd[2:0] : 3'h0;

	// Bus handshake state; never touched by the soft reset so a response always completes.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end else begin
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_known ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		s_axi_awready = !aw_held_reg;
		s_axi_wready  = !w_held_reg;
		s_axi_arready = !s_axi_rvalid;
	end

	// Configuration registers; the soft reset returns all of them to reset value.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prio_chan_reg   <= adc_ctrl_pkg::prio_ctrl_reset[3:0];
			hw_trig_reg     <= adc_ctrl_pkg::hw_trig_reset[7:4];
			mon0_cfg_reg    <= adc_ctrl_pkg::mon0_cfg_reset[5:0];
			mon0_cmp_reg    <= adc_ctrl_pkg::mon0_cmp_reset;
			norm_chan_reg   <= adc_ctrl_pkg::prio_chan_min;
			irq_mask_reg    <= adc_ctrl_pkg::irq_mask_reset;
		end else if (soft_fire) begin
			prio_chan_reg   <= adc_ctrl_pkg::prio_ctrl_reset[3:0];
			hw_trig_reg     <= adc_ctrl_pkg::hw_trig_reset[7:4];
			mon0_cfg_reg    <= adc_ctrl_pkg::mon0_cfg_reset[5:0];
			mon0_cmp_reg    <= adc_ctrl_pkg::mon0_cmp_reset;
			norm_chan_reg   <= adc_ctrl_pkg::prio_chan_min;
			irq_mask_reg    <= adc_ctrl_pkg::irq_mask_reset;
		end else begin
			if (wr_trig) begin
				hw_trig_reg <= wd[7:4];
			end
			if (prio_chan_ok) begin
				prio_chan_reg <= wd[3:0];
			end
			if (norm_chan_ok) begin
				norm_chan_reg <= wd[7:4];
			end
			if (wr_mon) begin
				mon0_cfg_reg <= wd[5:0];
			end
			if (wr_cmp) begin
				mon0_cmp_reg <= {wr_hi ? w_data_reg[9:8] : mon0_cmp_reg[9:8],
					wr_low ? w_data_reg[7:0] : mon0_cmp_reg[7:0]};
			end
			if (wr_mask) begin
				irq_mask_reg <= wd[2:0];
			end
		end
	end

	// Two-step software reset; any write in between disarms it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_arm_reg     <= 1'b0;
			soft_reset_pulse <= 1'b0;
		end else if (soft_fire) begin
			soft_arm_reg     <= 1'b0;
			soft_reset_pulse <= 1'b1;
		end else begin
			soft_reset_pulse <= 1'b0;
			if (wr_trig) begin
				soft_arm_reg <= (wd[1:0] == adc_ctrl_pkg::soft_reset_arm);
			end else if (wr_fire) begin
				soft_arm_reg <= 1'b0;
			end
		end
	end

	// A new start clears the flag so it never reads done while busy.
	// Completion still wins over a clearing read in the same cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prio_done_reg <= 1'b0;
		end else if (soft_fire) begin
			prio_done_reg <= 1'b0;
		end else if (go_prio) begin
			prio_done_reg <= 1'b0;
		end else if (prio_end) begin
			prio_done_reg <= 1'b1;
		end else if (rd_prio) begin
			prio_done_reg <= 1'b0;
		end
	end

	// Interrupt status is sticky; an event wins over a write-one clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_reg <= 3'h0;
			irq            <= 1'b0;
		end else if (soft_fire) begin
			irq_status_reg <= 3'h0;
			irq            <= 1'b0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
			irq <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_mask_reg);
		end
	end

	// Sequencer; a preempted normal conversion restarts once the priority one ends.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prio_pend_reg   <= 1'b0;
			norm_pend_reg   <= 1'b0;
			norm_resume_reg <= 1'b0;
			conv_cnt_reg    <= 16'h0000;
			state_reg       <= adc_ctrl_pkg::conv_idle;
			conv_start      <= 1'b0;
			conv_channel    <= 4'h0;
			conv_is_prio    <= 1'b0;
		end else if (soft_fire) begin
			prio_pend_reg   <= 1'b0;
			norm_pend_reg   <= 1'b0;
			norm_resume_reg <= 1'b0;
			conv_cnt_reg    <= 16'h0000;
			state_reg       <= adc_ctrl_pkg::conv_idle;
			conv_start      <= 1'b0;
			conv_is_prio    <= 1'b0;
		end else begin
			prio_pend_reg <= prio_req && !go_prio;
			norm_pend_reg <= norm_req && !go_norm && !(preempt && norm_pend_reg);
			if (preempt) begin
				norm_resume_reg <= 1'b1;
			end else if (go_norm) begin
				norm_resume_reg <= 1'b0;
			end
			state_reg <= state_next;
			if (go_prio || go_norm) begin
				conv_cnt_reg <= 16'h0000;
			end else if (state_reg != adc_ctrl_pkg::conv_idle) begin
				conv_cnt_reg <= conv_cnt_reg + 16'h0001;
			end
			conv_start <= go_prio || go_norm;
			if (go_prio) begin
				conv_channel <= prio_chan_eff;
			end else if (go_norm) begin
				conv_channel <= norm_chan_eff;
			end
			if (go_prio || go_norm) begin
				conv_is_prio <= go_prio;
			end
		end
	end

endmodule

/* File: tb/adc_ctrl_checker.sv */
`timescale 1ns/1ps
module adc_ctrl_checker (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        conv_start,
	input wire logic [3:0]  conv_channel,
	input wire logic        conv_is_prio,
	input wire logic        soft_reset_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic rd_ctrl_reg;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			rd_ctrl_reg <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			rd_ctrl_reg <= (s_axi_araddr == adc_ctrl_pkg::prio_ctrl_offset);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped before taken");
	a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before taken");
	a_arready_free: assert property (s_axi_arready != s_axi_rvalid)
		else $error("read address ready wrong");
	a_start_reads_zero: assert property (s_axi_rvalid && rd_ctrl_reg |-> !s_axi_rdata[5])
		else $error("start bit read back as one");
	a_done_not_busy: assert property (s_axi_rvalid && rd_ctrl_reg |-> !(s_axi_rdata[7]
		&& s_axi_rdata[6])) else $error("done and busy together");
	a_start_one_cycle: assert property (conv_start |=> !conv_start)
		else $error("start pulse too long");
	a_prio_chan_legal: assert property (conv_start && conv_is_prio |->
		conv_channel inside {[4'h4:4'hb]}) else $error("illegal priority channel");
	a_reset_one_cycle: assert property (soft_reset_pulse |=> !soft_reset_pulse)
		else $error("soft reset pulse too long");
endmodule
bind adc_priority_trigger_monitor_ctrl adc_ctrl_checker adc_ctrl_checker_inst (.clk, .rst_n,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.s_axi_bvalid, .s_axi_bready, .conv_start, .conv_channel, .conv_is_prio, .soft_reset_pulse);

/* File: tb/adc_far_side_model.sv */
`timescale 1ns/1ps
// Priority results depend on the channel and normal results on their slot, so the monitor sees both sides of its threshold.
module adc_far_side_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [2:0]  fire,
	input  wire logic        conv_start,
	input  wire logic [3:0]  conv_channel,
	input  wire logic        conv_is_prio,
	output logic             ext_trigger,
	output logic             timer5_compare0,
	output logic             timer6_compare0,
	output logic [9:0]       conv_result,
	output logic [79:0]      normal_results,
	output logic [9:0]       prio_result_register
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{timer6_compare0, timer5_compare0, ext_trigger} <= 3'h0;
			conv_result <= 10'h000;
			prio_result_register <= 10'h000;
		end else begin
			{timer6_compare0, timer5_compare0, ext_trigger} <= fire;
			if (conv_start)
				conv_result <= {conv_channel, 6'h20};
			if (conv_start && conv_is_prio)
				prio_result_register <= {conv_channel, 6'h20};
		end
	end
	for (genvar k = 0; k < 8; k++) begin : g_res
		assign normal_results[10*k+:10] = 10'(k * 48 + 16);
	end
endmodule

/* File: tb/adc_priority_trigger_monitor_ctrl_tb_top.sv */
`timescale 1ns/1ps
module adc_priority_trigger_monitor_ctrl_tb_top;
	localparam int cyc = 12;
	logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, ext_trigger, timer5_compare0, timer6_compare0, conv_start;
	logic        conv_is_prio, soft_reset_pulse, irq, last_prio;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0]  s_axi_wstrb, conv_channel, last_chan;
	logic [1:0]  s_axi_bresp, s_axi_rresp, b_rsp, r_rsp;
	logic [9:0]  conv_result, prio_result_register;
	logic [79:0] normal_results;
	logic [2:0]  fire;
	int          n_fail, tests_run, n_start, n_srst, k;
	logic [71:0] rows [8] = '{{8'h04, 32'hf0, 32'hf0}, {8'h04, 32'hf3, 32'hf0},
		{8'h08, 32'h3f, 32'h3f}, {8'h0c, 32'h3ff, 32'h3ff}, {8'h00, 32'h0b, 32'h0b},
		{8'h00, 32'h03, 32'h0b}, {8'h00, 32'h04, 32'h04}, {8'h18, 32'h07, 32'h07}};
	logic [12:0] trig [6] = '{{8'he0, 3'h2, 2'h3}, {8'ha0, 3'h2, 2'h0}, {8'he0, 3'h4, 2'h0},
		{8'hf0, 3'h4, 2'h2}, {8'hf0, 3'h1, 2'h0}, {8'hb0, 3'h2, 2'h0}};
	logic [12:0] mon [6] = '{{8'h31, 4'h6, 1'h1}, {8'h11, 4'h6, 1'h0}, {8'h11, 4'h5, 1'h1},
		{8'h10, 4'h5, 1'h0}, {8'h05, 4'h6, 1'h1}, {8'h25, 4'h6, 1'h0}};
	adc_priority_trigger_monitor_ctrl #(.conv_cycles(cyc)) adc_priority_trigger_monitor_ctrl_inst (
		.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ext_trigger, .timer5_compare0, .timer6_compare0, .conv_result, .normal_results,
		.prio_result_register, .conv_start, .conv_channel, .conv_is_prio, .soft_reset_pulse, .irq);
	adc_far_side_model adc_far_side_model_inst (.clk, .rst_n, .fire, .conv_start, .conv_channel,
		.conv_is_prio, .ext_trigger, .timer5_compare0, .timer6_compare0, .conv_result,
		.normal_results, .prio_result_register);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		n_srst += soft_reset_pulse;
		if (conv_start) begin
			n_start++;
			last_prio = conv_is_prio;
			last_chan = conv_channel;
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			{ta, tw, tb, b_rsp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) break;
		end
		if (!tb) n_fail++;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic tr, tv;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			{tr, tv, q, r_rsp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge clk);
			if (tr) s_axi_arvalid <= 1'b0;
			if (tv) break;
		end
		if (!tv) n_fail++;
		s_axi_rready <= 1'b0;
		@(posedge clk);
		chk(nm, e, q);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#4000000;
		n_fail++;
		stop_test();
	end
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, fire, n_start, n_srst} = '0;
		s_axi_wstrb = 4'hf;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			wr(rows[i][71:64], rows[i][63:32]);
			rc("register", rows[i][71:64], rows[i][31:0]);
		end
		wr(8'h1c, 32'h1);
		chk("bresp", 32'h2, b_rsp);
		rc("unmapped", 8'h1c, 32'h0);
		chk("rresp", 32'h2, r_rsp);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i])
			rc("reset", rows[i][71:64], 32'h0);
		repeat (30) @(posedge clk);
		wr(8'h00, 32'h26);
		rc("busy", 8'h00, 32'h46);
		repeat (2 * cyc) @(posedge clk);
		chk("launch", 32'h16, {last_prio, last_chan});
		rc("done", 8'h00, 32'h86);
		rc("cleared", 8'h00, 32'h06);
		chk("masked", 32'h0, irq);
		wr(8'h18, 32'h1);
		chk("irq", 32'h1, irq);
		wr(8'h14, 32'h1);
		chk("irq off", 32'h0, irq);
		foreach (trig[i]) begin
			wr(8'h04, {24'h0, trig[i][12:5]});
			k = n_start;
			fire <= trig[i][4:2];
			@(posedge clk);
			fire <= 3'h0;
			repeat (2 * cyc) @(posedge clk);
			chk("hw start", trig[i][1:0], {n_start != k, n_start != k && last_prio});
		end
		wr(8'h08, 32'h21);
		wr(8'h04, 32'hf2);
		wr(8'h08, 32'h21);
		wr(8'h04, 32'hf1);
		chk("disarmed", 32'h0, n_srst);
		wr(8'h04, 32'hf2);
		wr(8'h04, 32'hf1);
		chk("soft reset", 32'h1, n_srst);
		rc("monitor cfg", 8'h08, 32'h0);
		rc("trigger cfg", 8'h04, 32'h0);
		wr(8'h0c, 32'h180);
		foreach (mon[i]) begin
			wr(8'h14, 32'h7);
			wr(8'h08, {24'h0, mon[i][12:5]});
			wr(8'h00, 32'h20 | mon[i][4:1]);
			repeat (2 * cyc) @(posedge clk);
			rc("monitor", 8'h14, {29'h0, mon[i][0], 2'h1});
		end
		k = n_start;
		wr(8'h10, 32'h51);
		wr(8'h00, 32'h27);
		repeat (4 * cyc) @(posedge clk);
		chk("preempt", 32'h3, n_start - k);
		chk("resumed", 32'h05, {last_prio, last_chan});
		stop_test();
	end
endmodule
